// >>> ifps_pkg.sv
package ifps_pkg;
   // -----------------------------------------
   // Register offsets on the special-function bus
   // -----------------------------------------
   localparam logic [7:0] ADDR_TRIG = 8'ha4;
   localparam logic [7:0] ADDR_ALO = 8'ha6;
   localparam logic [7:0] ADDR_AHI = 8'ha7;
   localparam logic [7:0] ADDR_DATA = 8'hae;
   localparam logic [7:0] ADDR_CMD = 8'haf;
   localparam logic [7:0] ADDR_CHIP = 8'h9f;
   localparam logic [7:0] ADDR_GUARD = 8'hc7;
   // -----------------------------------------
   // Reset values
   // -----------------------------------------
   localparam logic [7:0] RST_CMD = 8'h30;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // -----------------------------------------
   // Field positions
   // -----------------------------------------
   localparam int REGION_HI = 7;
   localparam int REGION_LO = 6;
   localparam int OE_BIT = 5;
   localparam int CE_BIT = 4;
   localparam int CODE_HI = 3;
   localparam int PEN_BIT = 0;
   localparam int BOOT_BIT = 1;
   localparam int GO_BIT = 0;
   localparam int PAGE_BITS = 7;
   // -----------------------------------------
   // Commands, regions, guard keys, timing
   // -----------------------------------------
   localparam logic [3:0] CMD_READ = 4'h0;
   localparam logic [3:0] CMD_PROG = 4'h1;
   localparam logic [3:0] CMD_ERASE = 4'h2;
   localparam logic [1:0] REGION_CFG = 2'h3;
   localparam logic [7:0] KEY_FIRST = 8'haa;
   localparam logic [7:0] KEY_SECOND = 8'h55;
   localparam logic [2:0] GUARD_WIN_CYC = 3'h4;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_REQ = 3'b010,
      ST_WAIT = 3'b100
   } ifps_state_t;

   typedef enum logic [2:0] {
      GD_LOCKED = 3'b001,
      GD_KEY = 3'b010,
      GD_OPEN = 3'b100
   } ifps_guard_t;
endpackage : ifps_pkg

// >>> ifps_flash_seq.sv
// Summary of operation
// - Boot bit reads 1 after loader-region reboot
// - Setting programming enable starts RC oscillator
// - Enable cleared blocks launch, stops oscillator while ext_clk_sel is high
// - Command register: region, OE, CE, code
// - Command register resets to 0x30
// - Address is high byte and low byte
// - Read result lands in data register
// - Writing 1 to trigger bit 0 launches
// - CPU held while operation runs
// - CPU released when operation completes
// - Launch bit self-clears, always reads 0
// - Trigger reachable only through guarded write
// - Page erase clears aligned 128-byte page
// - Config writes only from loader code
`timescale 1ns/100ps
module ifps_flash_seq (
   input wire logic mclk,
   input wire logic rst,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic boot_from_loader,
   input wire logic cpu_in_loader,
   input wire logic ext_clk_sel,
   output logic rc_osc_en,
   output logic cpu_hold,
   output logic flash_req,
   output logic [17:0] flash_addr,
   output logic [3:0] flash_cmd,
   output logic flash_oe,
   output logic flash_ce,
   output logic [7:0] flash_wdata,
   input wire logic [7:0] flash_rdata,
   input wire logic flash_done
);
   // -----------------------------------------
   // Register state
   // -----------------------------------------
   logic [7:0] cmd_q, cmd_d;
   logic [7:0] alo_q, alo_d;
   logic [7:0] ahi_q, ahi_d;
   logic [7:0] fd_q, fd_d;
   logic pen_q, pen_d;
   logic boot_q, boot_d;
   logic boot_cap_q, boot_cap_d;
   logic [7:0] rdata_q, rdata_d;
   ifps_pkg::ifps_guard_t gd_q, gd_d;
   logic [2:0] gd_cnt_q, gd_cnt_d;
   ifps_pkg::ifps_state_t st_q, st_d;
   logic [17:0] op_addr_q, op_addr_d;
   logic [3:0] op_cmd_q, op_cmd_d;
   logic op_oe_q, op_oe_d;
   logic op_ce_q, op_ce_d;
   logic [7:0] op_wdata_q, op_wdata_d;
   logic wr_trig, wr_chip, guard_open, go_acc, go_block;
   logic [1:0] region;

   function automatic logic is_write_cmd(input logic [3:0] code);
      is_write_cmd = (code == ifps_pkg::CMD_PROG) || (code == ifps_pkg::CMD_ERASE);
   endfunction : is_write_cmd

   // -----------------------------------------
   // Guarded access and launch decode
   // -----------------------------------------
   always_comb begin
      region = cmd_q[ifps_pkg::REGION_HI:ifps_pkg::REGION_LO];
      guard_open = (gd_q == ifps_pkg::GD_OPEN);
      wr_trig = sfr_wr && (sfr_addr == ifps_pkg::ADDR_TRIG) && guard_open;
      wr_chip = sfr_wr && (sfr_addr == ifps_pkg::ADDR_CHIP) && guard_open;
      go_acc = wr_trig && sfr_wdata[ifps_pkg::GO_BIT] && pen_q
               && (st_q == ifps_pkg::ST_IDLE);
      go_block = (region == ifps_pkg::REGION_CFG) && is_write_cmd(cmd_q[ifps_pkg::CODE_HI:0])
                 && !cpu_in_loader;
   end

   always_comb begin
      gd_d = gd_q;
      gd_cnt_d = gd_cnt_q;
      if (sfr_wr && (sfr_addr == ifps_pkg::ADDR_GUARD)) begin
         if (sfr_wdata == ifps_pkg::KEY_FIRST) begin
            gd_d = ifps_pkg::GD_KEY;
         end else if (sfr_wdata == ifps_pkg::KEY_SECOND && gd_q == ifps_pkg::GD_KEY) begin
            gd_d = ifps_pkg::GD_OPEN;
            gd_cnt_d = ifps_pkg::GUARD_WIN_CYC;
         end else begin
            gd_d = ifps_pkg::GD_LOCKED;
         end
      end else if (sfr_wr) begin
         gd_d = ifps_pkg::GD_LOCKED;
      end else if (gd_q == ifps_pkg::GD_OPEN) begin
         if (gd_cnt_q == 3'h1) begin
            gd_d = ifps_pkg::GD_LOCKED;
         end
         gd_cnt_d = gd_cnt_q - 3'h1;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gd_q <= ifps_pkg::GD_LOCKED;
         gd_cnt_q <= 3'h0;
      end else begin
         gd_q <= gd_d;
         gd_cnt_q <= gd_cnt_d;
      end
   end

   // -----------------------------------------
   // Software registers
   // -----------------------------------------
   always_comb begin
      cmd_d = cmd_q;
      alo_d = alo_q;
      ahi_d = ahi_q;
      fd_d = fd_q;
      pen_d = pen_q;
      boot_d = boot_q;
      boot_cap_d = 1'b1;
      rdata_d = rdata_q;
      if (!boot_cap_q) begin
         boot_d = boot_from_loader;
      end
      if (sfr_wr) begin
         if (sfr_addr == ifps_pkg::ADDR_CMD) begin
            cmd_d = sfr_wdata;
         end else if (sfr_addr == ifps_pkg::ADDR_ALO) begin
            alo_d = sfr_wdata;
         end else if (sfr_addr == ifps_pkg::ADDR_AHI) begin
            ahi_d = sfr_wdata;
         end else if (sfr_addr == ifps_pkg::ADDR_DATA) begin
            fd_d = sfr_wdata;
         end
      end
      if (wr_chip) begin
         pen_d = sfr_wdata[ifps_pkg::PEN_BIT];
      end
      // Read result wins over a same-cycle software write
      if (st_q == ifps_pkg::ST_WAIT && flash_done && !is_write_cmd(op_cmd_q)) begin
         fd_d = flash_rdata;
      end
      if (sfr_rd) begin
         if (sfr_addr == ifps_pkg::ADDR_CMD) begin
            rdata_d = cmd_q;
         end else if (sfr_addr == ifps_pkg::ADDR_ALO) begin
            rdata_d = alo_q;
         end else if (sfr_addr == ifps_pkg::ADDR_AHI) begin
            rdata_d = ahi_q;
         end else if (sfr_addr == ifps_pkg::ADDR_DATA) begin
            rdata_d = fd_q;
         end else if (sfr_addr == ifps_pkg::ADDR_CHIP) begin
            rdata_d = ifps_pkg::RST_ZERO;
            rdata_d[ifps_pkg::BOOT_BIT] = boot_q;
            rdata_d[ifps_pkg::PEN_BIT] = pen_q;
         end else begin
            rdata_d = ifps_pkg::RST_ZERO;
         end
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cmd_q <= ifps_pkg::RST_CMD;
         alo_q <= ifps_pkg::RST_ZERO;
         ahi_q <= ifps_pkg::RST_ZERO;
         fd_q <= ifps_pkg::RST_ZERO;
         pen_q <= 1'b0;
         boot_q <= 1'b0;
         boot_cap_q <= 1'b0;
         rdata_q <= ifps_pkg::RST_ZERO;
      end else begin
         cmd_q <= cmd_d;
         alo_q <= alo_d;
         ahi_q <= ahi_d;
         fd_q <= fd_d;
         pen_q <= pen_d;
         boot_q <= boot_d;
         boot_cap_q <= boot_cap_d;
         rdata_q <= rdata_d;
      end
   end

   // -----------------------------------------
   // Operation sequencer
   // -----------------------------------------
   always_comb begin
      st_d = st_q;
      op_addr_d = op_addr_q;
      op_cmd_d = op_cmd_q;
      op_oe_d = op_oe_q;
      op_ce_d = op_ce_q;
      op_wdata_d = op_wdata_q;
      case (st_q)
         ifps_pkg::ST_IDLE: begin
            if (go_acc && !go_block) begin
               st_d = ifps_pkg::ST_REQ;
               op_addr_d = {region, ahi_q, alo_q};
               op_cmd_d = cmd_q[ifps_pkg::CODE_HI:0];
               op_oe_d = cmd_q[ifps_pkg::OE_BIT];
               op_ce_d = cmd_q[ifps_pkg::CE_BIT];
               op_wdata_d = fd_q;
               if (cmd_q[ifps_pkg::CODE_HI:0] == ifps_pkg::CMD_ERASE) begin
                  op_addr_d[ifps_pkg::PAGE_BITS-1:0] = '0;
               end
            end
         end
         ifps_pkg::ST_REQ: begin
            st_d = ifps_pkg::ST_WAIT;
         end
         ifps_pkg::ST_WAIT: begin
            if (flash_done) begin
               st_d = ifps_pkg::ST_IDLE;
            end
         end
         default: begin
            st_d = ifps_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st_q <= ifps_pkg::ST_IDLE;
         op_addr_q <= 18'h0_0000;
         op_cmd_q <= 4'h0;
         op_oe_q <= 1'b0;
         op_ce_q <= 1'b0;
         op_wdata_q <= ifps_pkg::RST_ZERO;
      end else begin
         st_q <= st_d;
         op_addr_q <= op_addr_d;
         op_cmd_q <= op_cmd_d;
         op_oe_q <= op_oe_d;
         op_ce_q <= op_ce_d;
         op_wdata_q <= op_wdata_d;
      end
   end

   // -----------------------------------------
   // Outputs
   // -----------------------------------------
   assign sfr_rdata = rdata_q;
   assign rc_osc_en = pen_q || !ext_clk_sel;
   assign cpu_hold = (st_q != ifps_pkg::ST_IDLE);
   assign flash_req = (st_q == ifps_pkg::ST_REQ);
   assign flash_addr = op_addr_q;
   assign flash_cmd = op_cmd_q;
   assign flash_oe = op_oe_q;
   assign flash_ce = op_ce_q;
   assign flash_wdata = op_wdata_q;

   // -----------------------------------------
   // Assertions
   // -----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   sequence seq_launch;
      go_acc && !go_block;
   endsequence
   sequence seq_finish;
      (st_q == ifps_pkg::ST_WAIT) && flash_done;
   endsequence

   boot_stable_a: assert property (boot_cap_q |=> $stable(boot_q))
      else $error("boot bit changed after capture");
   osc_on_a: assert property (pen_q |-> rc_osc_en)
      else $error("oscillator off while enabled");
   osc_off_a: assert property (!pen_q && ext_clk_sel |-> !rc_osc_en)
      else $error("oscillator on while disabled");
   cmd_latch_a: assert property (seq_launch |=> flash_cmd == $past(cmd_q[3:0])
      && flash_oe == $past(cmd_q[5]) && flash_ce == $past(cmd_q[4]))
      else $error("command not latched at launch");
   addr_path_a: assert property (seq_launch ##0 (cmd_q[3:0] != ifps_pkg::CMD_ERASE)
      |=> flash_addr[15:0] == {$past(ahi_q), $past(alo_q)})
      else $error("operation address wrong");
   read_capture_a: assert property (seq_finish ##0 !is_write_cmd(op_cmd_q)
      |=> fd_q == $past(flash_rdata))
      else $error("read byte not captured");
   hold_run_a: assert property (seq_launch |=> cpu_hold [*2])
      else $error("cpu not held during operation");
   release_done_a: assert property (seq_finish |=> !cpu_hold)
      else $error("cpu not released after completion");
   go_reads_zero_a: assert property (sfr_rd && sfr_addr == ifps_pkg::ADDR_TRIG
      |=> sfr_rdata == 8'h00)
      else $error("launch bit read nonzero");
   locked_trig_a: assert property (sfr_wr && sfr_addr == ifps_pkg::ADDR_TRIG
      && !guard_open |=> st_q == ifps_pkg::ST_IDLE)
      else $error("unguarded launch accepted");
   erase_align_a: assert property (flash_req && flash_cmd == ifps_pkg::CMD_ERASE
      |-> flash_addr[6:0] == 7'h00)
      else $error("erase address not page aligned");
   cfg_guard_a: assert property (go_acc && go_block |=> !cpu_hold)
      else $error("config write outside loader");
   pen_gate_a: assert property (wr_trig && !pen_q |=> st_q == ifps_pkg::ST_IDLE)
      else $error("launch while disabled");
endmodule : ifps_flash_seq

// >>> ifps_flash_model.sv
`timescale 1ns/100ps
module ifps_flash_model (
   input wire logic mclk,
   input wire logic rst,
   input wire logic flash_req,
   input wire logic [17:0] flash_addr,
   input wire logic [7:0] lat,
   output logic flash_done,
   output logic [7:0] flash_rdata
);
   logic [7:0] cnt_q;
   logic busy_q;
   // Fetched byte is the low address byte xor 5a; stale data never holds
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cnt_q <= 8'h00;
         busy_q <= 1'b0;
         flash_done <= 1'b0;
         flash_rdata <= 8'h00;
      end else begin
         flash_done <= 1'b0;
         flash_rdata <= ~flash_rdata;
         if (flash_req) begin
            busy_q <= 1'b1;
            cnt_q <= lat;
         end else if (busy_q && cnt_q == 8'h00) begin
            busy_q <= 1'b0;
            flash_done <= 1'b1;
            flash_rdata <= flash_addr[7:0] ^ 8'h5a;
         end else if (busy_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : ifps_flash_model

// >>> tb.sv
`timescale 1ns/100ps
module tb;
   logic mclk, rst, sfr_wr, sfr_rd, boot_from_loader, cpu_in_loader, ext_clk_sel;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, flash_wdata, flash_rdata, lat;
   logic rc_osc_en, cpu_hold, flash_req, flash_oe, flash_ce, flash_done;
   logic [17:0] flash_addr;
   logic [3:0] flash_cmd;
   int n_fail = 0;
   int samples_checked = 0;
   ifps_flash_seq uut (.mclk(mclk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
      .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .boot_from_loader(boot_from_loader), .cpu_in_loader(cpu_in_loader),
      .ext_clk_sel(ext_clk_sel), .rc_osc_en(rc_osc_en), .cpu_hold(cpu_hold),
      .flash_req(flash_req), .flash_addr(flash_addr), .flash_cmd(flash_cmd),
      .flash_oe(flash_oe), .flash_ce(flash_ce), .flash_wdata(flash_wdata),
      .flash_rdata(flash_rdata), .flash_done(flash_done));
   ifps_flash_model flash (.mclk(mclk), .rst(rst), .flash_req(flash_req),
      .flash_addr(flash_addr), .lat(lat), .flash_done(flash_done), .flash_rdata(flash_rdata));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   task automatic complete_run;
      if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", nm, exp, got);
         n_fail++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(posedge mclk);
      #1;
      sfr_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
      @(posedge mclk);
      #1;
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(posedge mclk);
      #1;
      sfr_rd = 1'b0;
      chk(nm, 32'(exp), 32'(sfr_rdata));
   endtask : rd
   task automatic gwr(input logic [7:0] a, input logic [7:0] d);
      wr(ifps_pkg::ADDR_GUARD, ifps_pkg::KEY_FIRST);
      wr(ifps_pkg::ADDR_GUARD, ifps_pkg::KEY_SECOND);
      wr(a, d);
   endtask : gwr
   // Load registers, launch, check the hold length against the latency
   task automatic op(input logic [7:0] c, input logic [15:0] ad, input logic [7:0] d,
      input logic go, input logic [17:0] xa);
      int i;
      wr(8'haf, c);
      wr(8'ha7, ad[15:8]);
      wr(8'ha6, ad[7:0]);
      wr(8'hae, d);
      gwr(8'ha4, 8'h01);
      chk("cpu_hold", 32'(go), 32'(cpu_hold));
      chk("flash_req", 32'(go), 32'(flash_req));
      if (go) begin
         chk("flash_addr", 32'(xa), 32'(flash_addr));
         chk("flash_ctl", 32'({c[5:0], d}), 32'({flash_oe, flash_ce, flash_cmd, flash_wdata}));
         for (i = 0; i < 60 && cpu_hold !== 1'b0; i++) begin
            @(posedge mclk);
            #1;
         end
         if (cpu_hold !== 1'b0) begin
            chk("cpu_hold_release", 32'd0, 32'(cpu_hold));
            complete_run();
         end
         chk("hold_cycles", 32'(lat) + 32'd3, 32'(i));
      end
   endtask : op
   task automatic t_reset;
      rd(8'haf, ifps_pkg::RST_CMD, "cmd_reset");
      rd(8'ha7, 8'h00, "addr_high_reset");
      rd(8'hae, 8'h00, "data_reset");
      rd(8'h9f, 8'h02, "boot_bit");
      chk("rc_osc_en", 32'd0, 32'(rc_osc_en));
   endtask : t_reset
   task automatic t_regs;
      wr(8'haf, 8'hc5);
      wr(8'ha7, 8'ha5);
      wr(8'ha6, 8'h5a);
      wr(8'h55, 8'h77);
      rd(8'haf, 8'hc5, "cmd_rw");
      rd(8'ha7, 8'ha5, "addr_high_rw");
      rd(8'ha6, 8'h5a, "addr_low_rw");
      rd(8'h55, 8'h00, "unmapped");
   endtask : t_regs
   task automatic t_guard;
      wr(8'h9f, 8'h01);
      rd(8'h9f, 8'h02, "chip_unguarded");
      op(8'h00, 16'h0010, 8'h00, 1'b0, 18'h0_0000);
      gwr(8'h9f, 8'h01);
      chk("rc_osc_en", 32'd1, 32'(rc_osc_en));
      wr(8'ha4, 8'h01);
      chk("cpu_hold", 32'd0, 32'(cpu_hold));
   endtask : t_guard
   task automatic t_ops;
      op(8'h30, 16'h1234, 8'h00, 1'b1, {2'h0, 16'h1234});
      rd(8'hae, 8'h6e, "read_data");
      rd(8'ha4, 8'h00, "trig_read");
      lat = 8'd20;
      op(8'h61, 16'hbeef, 8'hc3, 1'b1, {2'h1, 16'hbeef});
      rd(8'hae, 8'hc3, "prog_data");
      op(8'h22, 16'h12ff, 8'h00, 1'b1, {2'h0, 16'h1280});
   endtask : t_ops
   task automatic t_cfg;
      cpu_in_loader = 1'b0;
      op(8'he1, 16'h0000, 8'h11, 1'b0, 18'h0_0000);
      cpu_in_loader = 1'b1;
      op(8'he1, 16'h0000, 8'h11, 1'b1, {2'h3, 16'h0000});
   endtask : t_cfg
   task automatic t_off;
      gwr(8'h9f, 8'h00);
      chk("rc_osc_en", 32'd0, 32'(rc_osc_en));
      op(8'h00, 16'h0020, 8'h00, 1'b0, 18'h0_0000);
      ext_clk_sel = 1'b0;
      #1;
      chk("rc_osc_en", 32'd1, 32'(rc_osc_en));
   endtask : t_off
   initial begin
      rst = 1'b1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      lat = 8'd0;
      boot_from_loader = 1'b1;
      cpu_in_loader = 1'b1;
      ext_clk_sel = 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_reset();
      t_regs();
      t_guard();
      t_ops();
      t_cfg();
      t_off();
      complete_run();
   end
endmodule : tb
